// >>> sync_data_pkg.sv
// Constants for the serial unit sync-busy, address, data and debug registers
package sync_data_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_FIRST_CTRL  = 8'h00;
  localparam logic [7:0] OFF_SECOND_CTRL = 8'h04;
  localparam logic [7:0] OFF_INT_FLAG    = 8'h18;
  localparam logic [7:0] OFF_SYNC_STATUS = 8'h1c;
  localparam logic [7:0] OFF_MATCH_ADDR  = 8'h24;
  localparam logic [7:0] OFF_XFER_BUF    = 8'h28;
  localparam logic [7:0] OFF_DEBUG       = 8'h30;
  // Field positions
  localparam int SYNC_SOFT_RST_BIT = 0;
  localparam int SYNC_ENABLE_BIT   = 1;
  localparam int SYNC_CTL2_BIT     = 2;
  localparam int CTL1_SOFT_RST_BIT = 0;
  localparam int CTL1_ENABLE_BIT   = 1;
  localparam int CTL2_RXEN_BIT     = 17;
  localparam int FLAG_TX_EMPTY_BIT = 0;
  localparam int FLAG_RX_FULL_BIT  = 2;
  localparam int MASK_LSB        = 16;
  localparam int DBG_HALT_BIT    = 0;
  // Writable bits and reset values
  localparam logic [31:0] CTL2_WMASK    = 32'h0002_0000;
  localparam logic [31:0] CTL2_RESET    = 32'h0000_0000;
  localparam logic [7:0]  ADDR_RESET    = 8'h00;
  localparam logic [8:0]  DATA_RESET    = 9'h000;
  // Cross-domain settle time, rounded up to whole core cycles
  localparam int CLK_PERIOD_PS = 10000;
  localparam int SYNC_TIME_NS  = 40;
  localparam int SYNC_CYCLES   = (SYNC_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SYNC_CNT_W    = 4;
endpackage

// >>> sync_tracker.sv
// Busy tracker for one cross-domain synchronisation
`timescale 1ns/100ps
module sync_tracker (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // Request and status
  input  wire logic start,
  output logic      busy,
  output logic      done
);
  typedef enum logic [0:0] {
    TRK_IDLE = 1'b0,
    TRK_BUSY = 1'b1
  } trk_state_t;

  trk_state_t                                  state_r;
  logic [sync_data_pkg::SYNC_CNT_W-1:0]        cnt_r;

  // Hold busy for a fixed settle time; a new start while busy restarts it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= TRK_IDLE;
      cnt_r   <= '0;
    end else if (start) begin
      state_r <= TRK_BUSY;
      cnt_r   <= sync_data_pkg::SYNC_CNT_W'(sync_data_pkg::SYNC_CYCLES - 1);
    end else begin
      unique case (state_r)
        TRK_IDLE: cnt_r <= '0;
        TRK_BUSY: begin
          if (cnt_r == '0) begin
            state_r <= TRK_IDLE;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
      endcase
    end
  end

  assign busy = (state_r == TRK_BUSY);
  assign done = busy && (cnt_r == '0) && !start;
endmodule // sync_tracker

// >>> sync_data_regs.sv
// Sync-busy tracking, address match, data buffer and debug-halt registers
//
// Summary of operation
// [R1] Enabled second control write sets busy bit 2
// [R2] Second control write while busy gives bus error
// [R3] Enable bit write without soft reset sets busy bit 1
// [R4] Enable sync pending: discard non-reset writes, error
// [R5] Soft reset request sets busy bit 0
// [R6] Reset sync pending: drop every write, error
// [R7] Unused register bits read back as zero
// [R8] Address bits 23:16 hold match mask
// [R9] Address bits 7:0 hold match address
// [R10] Data read returns receive buffer contents
// [R11] Data write loads transmit buffer
// [R12] Software reads on receive, writes on empty
// [R13] Halt bit stops baud generator under debug
// [R14] Receive flag clears on read or disable
// [R15] Empty flag clears on write, sets when taken
// [R16] Sync status register is read only
`timescale 1ns/100ps
module sync_data_regs (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Peripheral bus slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Receive side of the shifter
  input  wire logic        rx_valid,
  input  wire logic [8:0]  rx_data_in,
  // Transmit side of the shifter
  input  wire logic        tx_take,
  output logic [8:0]       tx_data,
  output logic             tx_valid,
  // Configuration towards the serial core
  output logic             unit_enabled,
  output logic             receiver_enabled,
  output logic [31:0]      second_control_register,
  output logic [7:0]       match_address,
  output logic [7:0]       match_mask_field,
  // Debug halt
  input  wire logic        cpu_debug_halt,
  output logic             baud_run
);
  // Word-aligned offset compare used by every decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a[7:2] == off[7:2]);
  endfunction

  logic        ctl1_en_r;
  logic        enabled_r;
  logic [31:0] ctl2_r;
  logic [7:0]  addr_r;
  logic [7:0]  mask_r;
  logic [8:0]  rx_buf_r;
  logic [8:0]  tx_buf_r;
  logic        rx_full_r;
  logic        tx_empty_r;
  logic        halt_on_debug_r;
  logic [31:0] prdata_r;
  logic [31:0] rd_nxt;
  logic        wr_acc;
  logic        rd_acc;
  logic        wr_err;
  logic        wr_ok;
  logic        soft_rst_req;
  logic        ctl1_wr;
  logic        ctl2_wr;
  logic        ctl2_start;
  logic        rst_busy;
  logic        en_busy;
  logic        cb_busy;
  logic        rst_done;
  logic        en_done;
  logic        cb_done;
  logic [2:0]  sync_pending_status;

  // Bus phases; no wait states are ever inserted
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign pready = 1'b1;

  // Write gating while a synchronisation is in flight
  always_comb begin
    wr_err = 1'b0;
    if (wr_acc) begin
      if (rst_busy) begin
        wr_err = 1'b1; // R6
      end else if (en_busy && !(hit(paddr, sync_data_pkg::OFF_FIRST_CTRL)
                   && pwdata[sync_data_pkg::CTL1_SOFT_RST_BIT])) begin
        wr_err = 1'b1; // R4
      end else if (cb_busy && hit(paddr, sync_data_pkg::OFF_SECOND_CTRL)) begin
        wr_err = 1'b1; // R2
      end
    end
  end

  assign pslverr     = wr_err;
  assign wr_ok       = wr_acc && !wr_err;
  assign ctl1_wr      = wr_ok && hit(paddr, sync_data_pkg::OFF_FIRST_CTRL);
  assign soft_rst_req = ctl1_wr && pwdata[sync_data_pkg::CTL1_SOFT_RST_BIT]; // R5
  assign ctl2_wr      = wr_ok && hit(paddr, sync_data_pkg::OFF_SECOND_CTRL);
  assign ctl2_start   = ctl2_wr && enabled_r; // R1

  // One tracker per synchronised write kind
  sync_tracker u_rst_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .start   (soft_rst_req),
    .busy    (rst_busy),
    .done    (rst_done)
  );

  sync_tracker u_en_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .start   (ctl1_wr && !soft_rst_req), // R3
    .busy    (en_busy),
    .done    (en_done)
  );

  sync_tracker u_cb_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .start   (ctl2_start),
    .busy    (cb_busy),
    .done    (cb_done)
  );

  // Only three live bits; the rest of the word is tied low
  assign sync_pending_status = {cb_busy, en_busy, rst_busy};

  // Enable: written value held at once, takes effect after the settle time
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctl1_en_r <= 1'b0;
      enabled_r <= 1'b0;
    end else if (rst_done) begin
      ctl1_en_r <= 1'b0;
      enabled_r <= 1'b0;
    end else begin
      if (ctl1_wr && !soft_rst_req) begin
        ctl1_en_r <= pwdata[sync_data_pkg::CTL1_ENABLE_BIT];
      end
      if (en_done) begin
        enabled_r <= ctl1_en_r;
      end
    end
  end

  // Second control register, only documented bits writable
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctl2_r <= sync_data_pkg::CTL2_RESET;
    end else if (rst_done) begin
      ctl2_r <= sync_data_pkg::CTL2_RESET;
    end else if (ctl2_wr) begin
      ctl2_r <= pwdata & sync_data_pkg::CTL2_WMASK;
    end
  end

  // Address match fields
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      addr_r <= sync_data_pkg::ADDR_RESET;
      mask_r <= sync_data_pkg::ADDR_RESET;
    end else if (rst_done) begin
      addr_r <= sync_data_pkg::ADDR_RESET;
      mask_r <= sync_data_pkg::ADDR_RESET;
    end else if (wr_ok && hit(paddr, sync_data_pkg::OFF_MATCH_ADDR)) begin
      addr_r <= pwdata[7:0]; // R9
      mask_r <= pwdata[sync_data_pkg::MASK_LSB +: 8]; // R8
    end
  end

  // Receive buffer and its flag; a new character beats a same-cycle clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_buf_r  <= sync_data_pkg::DATA_RESET;
      rx_full_r <= 1'b0;
    end else if (rst_done) begin
      rx_buf_r  <= sync_data_pkg::DATA_RESET;
      rx_full_r <= 1'b0;
    end else if (rx_valid && receiver_enabled) begin
      rx_buf_r  <= rx_data_in;
      rx_full_r <= 1'b1;
    end else if ((rd_acc && hit(paddr, sync_data_pkg::OFF_XFER_BUF)) || !receiver_enabled) begin
      rx_full_r <= 1'b0; // R14
    end
  end

  // Transmit buffer; fresh data keeps the flag low even if the old word left
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_buf_r <= sync_data_pkg::DATA_RESET;
      tx_empty_r <= 1'b1;
    end else if (rst_done) begin
      tx_buf_r   <= sync_data_pkg::DATA_RESET;
      tx_empty_r <= 1'b1;
    end else if (wr_ok && hit(paddr, sync_data_pkg::OFF_XFER_BUF)) begin
      tx_buf_r   <= pwdata[8:0]; // R11
      tx_empty_r <= 1'b0; // R15
    end else if (tx_take) begin
      tx_empty_r <= 1'b1; // R15
    end
  end

  // Debug control survives a soft reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      halt_on_debug_r <= 1'b0;
    end else if (wr_ok && hit(paddr, sync_data_pkg::OFF_DEBUG)) begin
      halt_on_debug_r <= pwdata[sync_data_pkg::DBG_HALT_BIT];
    end
  end

  // Read mux; unmapped offsets and reserved bits read zero
  always_comb begin
    rd_nxt = '0;
    if (hit(paddr, sync_data_pkg::OFF_FIRST_CTRL)) begin
      rd_nxt[sync_data_pkg::CTL1_ENABLE_BIT] = ctl1_en_r;
    end else if (hit(paddr, sync_data_pkg::OFF_SECOND_CTRL)) begin
      rd_nxt = ctl2_r;
    end else if (hit(paddr, sync_data_pkg::OFF_INT_FLAG)) begin
      rd_nxt[sync_data_pkg::FLAG_TX_EMPTY_BIT] = tx_empty_r;
      rd_nxt[sync_data_pkg::FLAG_RX_FULL_BIT]  = rx_full_r;
    end else if (hit(paddr, sync_data_pkg::OFF_SYNC_STATUS)) begin
      rd_nxt[2:0] = sync_pending_status; // R7
    end else if (hit(paddr, sync_data_pkg::OFF_MATCH_ADDR)) begin
      rd_nxt[7:0] = addr_r;
      rd_nxt[sync_data_pkg::MASK_LSB +: 8] = mask_r;
    end else if (hit(paddr, sync_data_pkg::OFF_XFER_BUF)) begin
      rd_nxt[8:0] = rx_buf_r; // R10
    end else if (hit(paddr, sync_data_pkg::OFF_DEBUG)) begin
      rd_nxt[sync_data_pkg::DBG_HALT_BIT] = halt_on_debug_r;
    end
  end

  // Read data captured in the setup phase so it is stable for the access
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prdata_r <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata_r <= rd_nxt;
    end
  end

  // Outputs; a write to the status offset hits no register at all (R16)
  assign prdata                  = prdata_r;
  assign tx_data                 = tx_buf_r;
  assign tx_valid                = !tx_empty_r;
  assign unit_enabled            = enabled_r;
  assign receiver_enabled        = enabled_r && ctl2_r[sync_data_pkg::CTL2_RXEN_BIT];
  assign second_control_register = ctl2_r;
  assign match_address           = addr_r;
  assign match_mask_field        = mask_r;
  assign baud_run                = !(halt_on_debug_r && cpu_debug_halt); // R13

  // Checks
  sequence s_wr(logic [7:0] off);
    psel && penable && pwrite && paddr[7:2] == off[7:2];
  endsequence
  sequence s_held_then_free(logic b);
    b [*4] ##1 !b;
  endsequence

  property p_ctl2_busy;
    @(posedge clk_sys) disable iff (!rst_n)
    (s_wr(sync_data_pkg::OFF_SECOND_CTRL) and (!pslverr && unit_enabled && !rst_done))
      |=> s_held_then_free(sync_pending_status[2]);
  endproperty
  a_ctl2_busy: assert property (p_ctl2_busy) else $error("second control busy wrong"); // R1

  property p_ctl2_err;
    @(posedge clk_sys) disable iff (!rst_n)
    (s_wr(sync_data_pkg::OFF_SECOND_CTRL) and sync_pending_status[2]) |-> pslverr;
  endproperty
  a_ctl2_err: assert property (p_ctl2_err) else $error("second control no error"); // R2

  property p_en_busy;
    @(posedge clk_sys) disable iff (!rst_n)
    (s_wr(sync_data_pkg::OFF_FIRST_CTRL) and (!pslverr && !pwdata[0]))
      |=> s_held_then_free(sync_pending_status[1]);
  endproperty
  a_en_busy: assert property (p_en_busy) else $error("enable busy wrong"); // R3

  property p_en_discard;
    @(posedge clk_sys) disable iff (!rst_n)
    (psel && penable && pwrite && sync_pending_status[1] && paddr[7:2] != 6'h00)
      |-> pslverr ##1 $stable(match_address) && $stable(tx_data);
  endproperty
  a_en_discard: assert property (p_en_discard) else $error("write not discarded"); // R4

  property p_rst_busy;
    @(posedge clk_sys) disable iff (!rst_n)
    (s_wr(sync_data_pkg::OFF_FIRST_CTRL) and (!pslverr && pwdata[0]))
      |=> s_held_then_free(sync_pending_status[0]) ##0 !unit_enabled;
  endproperty
  a_rst_busy: assert property (p_rst_busy) else $error("reset busy wrong"); // R5

  property p_rst_drop;
    @(posedge clk_sys) disable iff (!rst_n)
    (psel && penable && pwrite && sync_pending_status[0]) |-> pslverr;
  endproperty
  a_rst_drop: assert property (p_rst_drop) else $error("write not dropped"); // R6

  property p_status_zero;
    @(posedge clk_sys) disable iff (!rst_n)
    (psel && penable && !pwrite && paddr[7:2] == 6'h07) |-> prdata[31:3] == '0;
  endproperty
  a_status_zero: assert property (p_status_zero) else $error("reserved bits set"); // R7

  property p_addr_fields;
    @(posedge clk_sys) disable iff (!rst_n)
    (s_wr(sync_data_pkg::OFF_MATCH_ADDR) and (!pslverr && !rst_done))
      |=> match_mask_field == $past(pwdata[23:16]) && match_address == $past(pwdata[7:0]);
  endproperty
  a_addr_fields: assert property (p_addr_fields) else $error("address fields wrong"); // R8

  property p_rx_read;
    @(posedge clk_sys) disable iff (!rst_n)
    (psel && !penable && !pwrite && paddr[7:2] == 6'h0a) |=> prdata[8:0] == $past(rx_buf_r);
  endproperty
  a_rx_read: assert property (p_rx_read) else $error("data read wrong"); // R10

  property p_tx_load;
    @(posedge clk_sys) disable iff (!rst_n)
    (s_wr(sync_data_pkg::OFF_XFER_BUF) and (!pslverr && !rst_done))
      |=> tx_data == $past(pwdata[8:0]) && tx_valid;
  endproperty
  a_tx_load: assert property (p_tx_load) else $error("tx load wrong"); // R11

  property p_dbg;
    @(posedge clk_sys) disable iff (!rst_n)
    cpu_debug_halt && halt_on_debug_r |-> !baud_run;
  endproperty
  a_dbg: assert property (p_dbg) else $error("baud not halted"); // R13

  property p_rx_full_clear;
    @(posedge clk_sys) disable iff (!rst_n)
    (psel && penable && !pwrite && paddr[7:2] == 6'h0a && !rx_valid) |=> !rx_full_r;
  endproperty
  a_rx_full_clear: assert property (p_rx_full_clear) else $error("receive flag kept"); // R14

  property p_tx_empty_set;
    @(posedge clk_sys) disable iff (!rst_n)
    (tx_take && !(psel && penable && pwrite)) |=> !tx_valid;
  endproperty
  a_tx_empty_set: assert property (p_tx_empty_set) else $error("empty flag not set"); // R15

  property p_status_ro;
    @(posedge clk_sys) disable iff (!rst_n)
    (s_wr(sync_data_pkg::OFF_SYNC_STATUS) and (sync_pending_status == 3'b000))
      |=> sync_pending_status == 3'b000;
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status written"); // R16
endmodule // sync_data_regs

// >>> shifter_peer.sv
// Behavioural shifter partner: feeds received characters, takes transmit data
`timescale 1ns/100ps
module shifter_peer (
  // Clock
  input  wire logic       clk_sys,
  // Transmit buffer handshake
  input  wire logic       tx_valid,
  input  wire logic [3:0] take_delay,
  output logic            tx_take,
  // Received characters
  output logic            rx_valid,
  output logic [8:0]      rx_data_in
);
  initial begin
    tx_take = 1'b0;
    rx_valid = 1'b0;
    rx_data_in = 9'h000;
  end

  // One character pulse; data inverted after so a stale value never matches
  task automatic send(input logic [8:0] c);
    rx_valid <= 1'b1;
    rx_data_in <= c;
    @(negedge clk_sys);
    rx_valid <= 1'b0;
    rx_data_in <= ~c;
  endtask

  // Take pending data after a stall, as a slow shifter would
  always begin
    @(negedge clk_sys);
    if (tx_valid === 1'b1) begin
      repeat (take_delay) @(negedge clk_sys);
      tx_take <= 1'b1;
      @(negedge clk_sys);
      tx_take <= 1'b0;
    end
  end
endmodule // shifter_peer

// >>> serial_port_sync_data_regs_tb_top.sv
// Self-checking bench for the sync-busy, address, data and debug registers
`timescale 1ns/100ps
module serial_port_sync_data_regs_tb_top;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        cpu_debug_halt = 1'b0;
  logic [3:0]  take_delay = 4'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, rx_valid, tx_take, tx_valid;
  logic        unit_enabled, receiver_enabled, baud_run;
  logic [8:0]  rx_data_in, tx_data;
  logic [31:0] second_control_register;
  logic [7:0]  match_address, match_mask_field;
  logic [31:0] rd_v, exp_addr;
  logic [8:0]  ch;
  logic        err_v, rdy_v;
  logic [8:0]  rx_q[$];
  int          n_errors = 0;
  int          check_count = 0;
  int          cyc = 0;

  always #5 clk_sys = ~clk_sys;

  sync_data_regs sync_data_regs_inst (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid), .rx_data_in(rx_data_in),
    .tx_take(tx_take), .tx_data(tx_data), .tx_valid(tx_valid),
    .unit_enabled(unit_enabled), .receiver_enabled(receiver_enabled),
    .second_control_register(second_control_register), .match_address(match_address),
    .match_mask_field(match_mask_field), .cpu_debug_halt(cpu_debug_halt),
    .baud_run(baud_run));

  shifter_peer shifter_peer_inst (.clk_sys(clk_sys), .tx_valid(tx_valid),
    .take_delay(take_delay), .tx_take(tx_take), .rx_valid(rx_valid),
    .rx_data_in(rx_data_in));

  task automatic print_verdict();
    if (n_errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer; no wait states, answer taken at the access edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(negedge clk_sys);
    psel = 1'b1;
    pwrite = w;
    paddr = a;
    pwdata = d;
    @(negedge clk_sys);
    penable = 1'b1;
    @(posedge clk_sys);
    rd_v = prdata;
    err_v = pslverr;
    rdy_v = pready;
    @(negedge clk_sys);
    psel = 1'b0;
    penable = 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
    apb(1'b1, a, d);
    chk("pslverr", {31'h0, err_v}, {31'h0, e});
    chk("pready", {31'h0, rdy_v}, 32'h1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("prdata", rd_v, e);
  endtask

  // Hang guard, well above the expected run length
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end

  initial begin
    void'($urandom(78));
    repeat (16) @(negedge clk_sys);
    rst_n = 1'b1;
    chk("baud_run", {31'h0, baud_run}, 32'h1);
    rd(sync_data_pkg::OFF_SYNC_STATUS, 32'h0);
    rd(8'h3c, 32'h0);
    rd(sync_data_pkg::OFF_XFER_BUF, 32'h0);
    rd(sync_data_pkg::OFF_INT_FLAG, 32'h1);
    wr(sync_data_pkg::OFF_SYNC_STATUS, 32'hffffffff, 1'b0);
    rd(sync_data_pkg::OFF_SYNC_STATUS, 32'h0);
    // Address register model keeps only the two byte fields
    repeat (3) begin
      exp_addr = $urandom();
      wr(sync_data_pkg::OFF_MATCH_ADDR, exp_addr, 1'b0);
      exp_addr = exp_addr & 32'h00ff00ff;
      rd(sync_data_pkg::OFF_MATCH_ADDR, exp_addr);
      chk("addr", {24'h0, match_address}, {24'h0, exp_addr[7:0]});
      chk("mask", {24'h0, match_mask_field}, {24'h0, exp_addr[23:16]});
    end
    wr(sync_data_pkg::OFF_DEBUG, 32'hff, 1'b0);
    rd(sync_data_pkg::OFF_DEBUG, 32'h1);
    cpu_debug_halt = 1'b1;
    @(negedge clk_sys);
    chk("baud_run", {31'h0, baud_run}, 32'h0);
    wr(sync_data_pkg::OFF_DEBUG, 32'h0, 1'b0);
    chk("baud_run", {31'h0, baud_run}, 32'h1);
    // Disabled unit: second control write is immediate
    wr(sync_data_pkg::OFF_SECOND_CTRL, 32'hffffffff, 1'b0);
    rd(sync_data_pkg::OFF_SYNC_STATUS, 32'h0);
    chk("ctrl2", second_control_register, sync_data_pkg::CTL2_WMASK);
    // Enable, then a write inside the sync window is refused
    wr(sync_data_pkg::OFF_FIRST_CTRL, 32'h2, 1'b0);
    wr(sync_data_pkg::OFF_MATCH_ADDR, 32'h0, 1'b1);
    repeat (6) @(negedge clk_sys);
    rd(sync_data_pkg::OFF_MATCH_ADDR, exp_addr);
    chk("enabled", {31'h0, receiver_enabled}, 32'h1);
    // Received characters, read only while the flag is up
    repeat (3) begin
      ch = 9'($urandom());
      rx_q.push_back(ch);
      @(negedge clk_sys);
      shifter_peer_inst.send(ch);
      repeat (2) @(negedge clk_sys);
      rd(sync_data_pkg::OFF_INT_FLAG, 32'h5);
      rd(sync_data_pkg::OFF_XFER_BUF, {23'h0, rx_q.pop_front()});
      rd(sync_data_pkg::OFF_INT_FLAG, 32'h1);
    end
    // Transmit with a stalling and a prompt shifter
    for (int d = 8; d >= 0; d -= 8) begin
      take_delay = 4'(d);
      ch = 9'($urandom());
      wr(sync_data_pkg::OFF_XFER_BUF, {23'($urandom()), ch}, 1'b0);
      chk("tx_data", {23'h0, tx_data}, {23'h0, ch});
      chk("tx_valid", {31'h0, tx_valid}, 32'h1);
      if (d == 8) begin
        rd(sync_data_pkg::OFF_INT_FLAG, 32'h0);
      end
      repeat (12) @(negedge clk_sys);
      rd(sync_data_pkg::OFF_INT_FLAG, 32'h1);
    end
    // Disabling the receiver drops an unread character
    @(negedge clk_sys);
    shifter_peer_inst.send(9'h1a5);
    wr(sync_data_pkg::OFF_SECOND_CTRL, 32'h0, 1'b0);
    repeat (8) @(negedge clk_sys);
    rd(sync_data_pkg::OFF_INT_FLAG, 32'h1);
    wr(sync_data_pkg::OFF_SECOND_CTRL, 32'h20000, 1'b0);
    rd(sync_data_pkg::OFF_SYNC_STATUS, 32'h4);
    repeat (6) @(negedge clk_sys);
    wr(sync_data_pkg::OFF_SECOND_CTRL, 32'h0, 1'b0);
    wr(sync_data_pkg::OFF_SECOND_CTRL, 32'h20000, 1'b1);
    repeat (6) @(negedge clk_sys);
    chk("ctrl2", second_control_register, 32'h0);
    wr(sync_data_pkg::OFF_FIRST_CTRL, 32'h0, 1'b0);
    wr(sync_data_pkg::OFF_DEBUG, 32'h1, 1'b1);
    repeat (6) @(negedge clk_sys);
    wr(sync_data_pkg::OFF_FIRST_CTRL, 32'h2, 1'b0);
    rd(sync_data_pkg::OFF_SYNC_STATUS, 32'h2);
    repeat (6) @(negedge clk_sys);
    // Soft reset: busy bit, dropped writes, debug register kept
    wr(sync_data_pkg::OFF_DEBUG, 32'h1, 1'b0);
    wr(sync_data_pkg::OFF_FIRST_CTRL, 32'h1, 1'b0);
    rd(sync_data_pkg::OFF_SYNC_STATUS, 32'h1);
    repeat (6) @(negedge clk_sys);
    wr(sync_data_pkg::OFF_FIRST_CTRL, 32'h1, 1'b0);
    wr(sync_data_pkg::OFF_FIRST_CTRL, 32'h2, 1'b1);
    repeat (6) @(negedge clk_sys);
    chk("enabled", {31'h0, unit_enabled}, 32'h0);
    rd(sync_data_pkg::OFF_MATCH_ADDR, 32'h0);
    rd(sync_data_pkg::OFF_DEBUG, 32'h1);
    chk("baud_run", {31'h0, baud_run}, 32'h0);
    print_verdict();
  end
endmodule // serial_port_sync_data_regs_tb_top
